// File: core/pdl_pkg.sv
// Behaviour
// - divider code 0..4 picks /1,/2,/4,/8,/16; codes 5..7 pick /8
// - five independent divider select fields, one per output clock
// - reset: output 0 /1, output 1 /2, output 2 /4, outputs 3-4 /8
// - with hold enabled, enter hold at first missing reference cycle
// - hold enable resets to 0, so hold is off after reset
// - lock high after five successive periods with edges inside window
// - lock window width chosen by two-bit field at bits 6 and 7
// - hold enable bit written 1 enables hold, written 0 disables it
// - window codes 0..3 name 1.2, 1.8, 2.4, 3 ns, each giving one core cycle; code 0 default
package pdl_pkg;
   // *****************************************************************
   // clock and timing
   // *****************************************************************
   localparam int CLK_FREQ_MHZ  = 100;
   localparam int CLK_PERIOD_PS = 1000000 / CLK_FREQ_MHZ;
   localparam int WIN0_PS = 1200;
   localparam int WIN1_PS = 1800;
   localparam int WIN2_PS = 2400;
   localparam int WIN3_PS = 3000;
   // longest time: round down, but never below one cycle
   localparam int WIN0_CYC = (WIN0_PS / CLK_PERIOD_PS < 1) ? 1
                             : WIN0_PS / CLK_PERIOD_PS;
   localparam int WIN1_CYC = (WIN1_PS / CLK_PERIOD_PS < 1) ? 1
                             : WIN1_PS / CLK_PERIOD_PS;
   localparam int WIN2_CYC = (WIN2_PS / CLK_PERIOD_PS < 1) ? 1
                             : WIN2_PS / CLK_PERIOD_PS;
   localparam int WIN3_CYC = (WIN3_PS / CLK_PERIOD_PS < 1) ? 1
                             : WIN3_PS / CLK_PERIOD_PS;
   localparam int GOOD_PERIODS = 5;

   // *****************************************************************
   // register map
   // *****************************************************************
   localparam logic [3:0]  REG_DIVSEL = 4'h0;
   localparam logic [3:0]  REG_CTRL   = 4'h4;
   localparam logic [3:0]  REG_STATUS = 4'h8;
   localparam int          NUM_OUT    = 5;
   localparam int          SEL_W      = 3;
   localparam logic [14:0] DIVSEL_RST = 15'h3688;
   localparam int          CTRL_HOLD_BIT = 2;
   localparam int          CTRL_WIN_LSB  = 6;
   localparam logic [1:0]  WIN_RST       = 2'h0;
   localparam int          STAT_LOCK_BIT = 0;
   localparam int          STAT_HOLD_BIT = 1;
   localparam int          STAT_CNT_LSB  = 4;

   // *****************************************************************
   // divider select codes
   // *****************************************************************
   localparam logic [2:0] SEL_DIV1  = 3'h0;
   localparam logic [2:0] SEL_DIV2  = 3'h1;
   localparam logic [2:0] SEL_DIV4  = 3'h2;
   localparam logic [2:0] SEL_DIV8  = 3'h3;
   localparam logic [2:0] SEL_DIV16 = 3'h4;
endpackage

// File: core/pdl_core.sv
`timescale 1ns/1ps
module pdl_core
   import pdl_pkg::*;
#(
   parameter int AGE_W = 16
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              resetn,
   // register port
   input  wire logic [3:0]        regAddr,
   input  wire logic [31:0]       regWdata,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic      [31:0]       regRdata,
   // phase detector and oscillator pins
   input  wire logic              refIn,
   input  wire logic              fbIn,
   input  wire logic              oscillatorClockInput,
   // outputs
   output logic [NUM_OUT-1:0]     outputClock,
   output logic                   lockDetect,
   output logic                   holdActive
);
   // *****************************************************************
   // elaboration check
   // *****************************************************************
   if (AGE_W < 4 || AGE_W > 30) begin : g_bad_age
      $error("AGE_W must lie between 4 and 30");
   end

   // *****************************************************************
   // state
   // *****************************************************************
   logic [2:0]       pinS1, pinS2, pinS3, pinLvl;
   logic [14:0]      divSel;
   logic             holdEn;
   logic [1:0]       lockWindowSelect;
   logic [3:0]       divCnt;
   logic [AGE_W-1:0] refAge, fbAge, refPeriod;
   logic             periodValid, pending, pairOk;
   logic [2:0]       goodCnt;
   logic [2:0]       next_pinLvl;
   logic [14:0]      next_divSel;
   logic             next_holdEn;
   logic [1:0]       next_lockWindowSelect;
   logic [3:0]       next_divCnt;
   logic [AGE_W-1:0] next_refAge, next_fbAge, next_refPeriod;
   logic             next_periodValid, next_pending, next_pairOk;
   logic [2:0]       next_goodCnt;
   logic [NUM_OUT-1:0] next_outputClock;
   logic             next_lockDetect, next_holdActive;
   logic [31:0]      next_regRdata;
   logic [2:0]       pinRise;
   logic             refEdge, fbEdge, oscEdge, judge;
   logic [AGE_W-1:0] winCyc, missLimit;
   logic [AGE_W-1:0] ageMax;

   // *****************************************************************
   // pin synchronisers and edge detect
   // *****************************************************************
   // a level counts once the second and third stages agree
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         next_pinLvl[i] = (pinS2[i] == pinS3[i]) ? pinS3[i] : pinLvl[i];
      end
      pinRise = next_pinLvl & ~pinLvl;
      refEdge = pinRise[0];
      fbEdge  = pinRise[1];
      oscEdge = pinRise[2];
   end

   // *****************************************************************
   // lock window width
   // *****************************************************************
   // all widths sit below one core cycle, so every code gives one cycle
   always_comb begin
      case (lockWindowSelect)
         2'h0:    winCyc = AGE_W'(WIN0_CYC);
         2'h1:    winCyc = AGE_W'(WIN1_CYC);
         2'h2:    winCyc = AGE_W'(WIN2_CYC);
         2'h3:    winCyc = AGE_W'(WIN3_CYC);
         default: winCyc = AGE_W'(WIN0_CYC);
      endcase
      ageMax    = '1;
      // a reference edge late by half a period counts as missing
      missLimit = refPeriod + (refPeriod >> 1);
   end

   // *****************************************************************
   // next-state logic
   // *****************************************************************
   always_comb begin
      // register writes
      next_divSel           = divSel;
      next_holdEn           = holdEn;
      next_lockWindowSelect = lockWindowSelect;
      if (regWr && regAddr == REG_DIVSEL) begin
         next_divSel = regWdata[14:0];
      end
      if (regWr && regAddr == REG_CTRL) begin
         next_holdEn = regWdata[CTRL_HOLD_BIT];
         next_lockWindowSelect =
            regWdata[CTRL_WIN_LSB +: 2];
      end
      // one shared counter keeps all outputs in step with each other
      next_divCnt = oscEdge ? divCnt + 4'h1 : divCnt;
      // per output ratio select
      for (int i = 0; i < NUM_OUT; i++) begin
         case (divSel[i*SEL_W +: SEL_W])
            SEL_DIV1:  next_outputClock[i] = pinLvl[2];
            SEL_DIV2:  next_outputClock[i] = divCnt[0];
            SEL_DIV4:  next_outputClock[i] = divCnt[1];
            SEL_DIV8:  next_outputClock[i] = divCnt[2];
            SEL_DIV16: next_outputClock[i] = divCnt[3];
            default:   next_outputClock[i] = divCnt[2];
         endcase
      end
      // edge ages, saturating
      next_refAge = refEdge ? '0
                  : (refAge == ageMax ? refAge : refAge + 1'b1);
      next_fbAge  = fbEdge ? '0
                  : (fbAge == ageMax ? fbAge : fbAge + 1'b1);
      next_refPeriod   = refPeriod;
      next_periodValid = periodValid;
      // a late edge closes a gap, not a period, so the learned value
      // stays; a reference slowed by more than half a period is relearned only after a saturated gap
      if (refEdge && refAge != ageMax
          && (!periodValid || refAge < missLimit)) begin
         next_refPeriod   = refAge + 1'b1;
         next_periodValid = 1'b1;
      end else if (refEdge && refAge == ageMax) begin
         next_periodValid = 1'b0;
      end
      // hold: entered at first missing reference edge, left on return
      next_holdActive = holdActive;
      if (!holdEn || refEdge) begin
         next_holdActive = 1'b0;
      end else if (periodValid && refAge == missLimit) begin
         next_holdActive = 1'b1;
      end
      // pair judging: feedback edge must fall inside window of ref edge
      next_pending = pending;
      next_pairOk  = pairOk;
      judge        = 1'b0;
      if (refEdge) begin
         next_pending = 1'b1;
         next_pairOk  = (fbAge < winCyc) || fbEdge;
      end else if (pending) begin
         if (fbEdge && refAge < winCyc) begin
            next_pairOk = 1'b1;
         end
         if (refAge >= winCyc) begin
            judge        = 1'b1;
            next_pending = 1'b0;
         end
      end
      next_goodCnt = goodCnt;
      if (judge) begin
         if (!pairOk) begin
            next_goodCnt = 3'h0;
         end else if (goodCnt != 3'(GOOD_PERIODS)) begin
            next_goodCnt = goodCnt + 3'h1;
         end
      end
      next_lockDetect = (next_goodCnt == 3'(GOOD_PERIODS));
      // read data stands only in the cycle after the strobe
      next_regRdata = 32'h0000_0000;
      if (regRd) begin
         case (regAddr)
            REG_DIVSEL: next_regRdata = {17'h0_0000, divSel};
            REG_CTRL: begin
               next_regRdata[CTRL_HOLD_BIT]     = holdEn;
               next_regRdata[CTRL_WIN_LSB +: 2] = lockWindowSelect;
            end
            REG_STATUS: begin
               next_regRdata[STAT_LOCK_BIT]     = lockDetect;
               next_regRdata[STAT_HOLD_BIT]     = holdActive;
               next_regRdata[STAT_CNT_LSB +: 3] = goodCnt;
            end
            default: next_regRdata = 32'h0000_0000;
         endcase
      end
   end

   // *****************************************************************
   // registers
   // *****************************************************************
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pinS1            <= 3'h0;
         pinS2            <= 3'h0;
         pinS3            <= 3'h0;
         pinLvl           <= 3'h0;
         divSel           <= DIVSEL_RST;
         holdEn           <= 1'b0;
         lockWindowSelect <= WIN_RST;
         divCnt           <= 4'h0;
         refAge           <= '1;
         fbAge            <= '1;
         refPeriod        <= '0;
         periodValid      <= 1'b0;
         pending          <= 1'b0;
         pairOk           <= 1'b0;
         goodCnt          <= 3'h0;
         outputClock      <= '0;
         lockDetect       <= 1'b0;
         holdActive       <= 1'b0;
         regRdata         <= 32'h0000_0000;
      end else begin
         pinS1            <= {oscillatorClockInput, fbIn, refIn};
         pinS2            <= pinS1;
         pinS3            <= pinS2;
         pinLvl           <= next_pinLvl;
         divSel           <= next_divSel;
         holdEn           <= next_holdEn;
         lockWindowSelect <= next_lockWindowSelect;
         divCnt           <= next_divCnt;
         refAge           <= next_refAge;
         fbAge            <= next_fbAge;
         refPeriod        <= next_refPeriod;
         periodValid      <= next_periodValid;
         pending          <= next_pending;
         pairOk           <= next_pairOk;
         goodCnt          <= next_goodCnt;
         outputClock      <= next_outputClock;
         lockDetect       <= next_lockDetect;
         holdActive       <= next_holdActive;
         regRdata         <= next_regRdata;
      end
   end

   // *****************************************************************
   // checks
   // *****************************************************************
   AST_DIV1_FOLLOWS: assert property (@(posedge core_clk)
      disable iff (!resetn)
      divSel[2:0] == SEL_DIV1 |=> outputClock[0] == $past(pinLvl[2]))
      else $error("divide by one output does not follow oscillator");
   AST_HIGH_CODES: assert property (@(posedge core_clk)
      disable iff (!resetn)
      divSel[14:12] > SEL_DIV16 |=> outputClock[4] == $past(divCnt[2]))
      else $error("codes above four do not divide by eight");
   AST_RESET_SEL: assert property (@(posedge core_clk)
      disable iff (!resetn)
      $rose(resetn) |-> divSel == DIVSEL_RST)
      else $error("divider selects wrong after reset");
   AST_HOLD_OFF: assert property (@(posedge core_clk)
      disable iff (!resetn)
      $rose(resetn) |-> !holdEn ##1 !holdActive)
      else $error("hold enabled after reset");
   AST_HOLD_GATED: assert property (@(posedge core_clk)
      disable iff (!resetn)
      holdActive |-> $past(holdEn))
      else $error("hold active without enable");
   AST_HOLD_ENTRY: assert property (@(posedge core_clk)
      disable iff (!resetn)
      holdEn && periodValid && refAge == missLimit && !refEdge
      |=> holdActive)
      else $error("hold not entered at missing reference cycle");
   AST_LOCK_FIVE: assert property (@(posedge core_clk)
      disable iff (!resetn)
      $rose(lockDetect) |-> goodCnt == 3'(GOOD_PERIODS)
      && $past(goodCnt) == 3'(GOOD_PERIODS - 1))
      else $error("lock rose without five good periods");
   AST_LOCK_DROP: assert property (@(posedge core_clk)
      disable iff (!resetn)
      judge && !pairOk |=> !lockDetect ##1 !lockDetect)
      else $error("lock kept after out-of-window pair");
   AST_WIN_WRITE: assert property (@(posedge core_clk)
      disable iff (!resetn)
      regWr && regAddr == REG_CTRL
      |=> lockWindowSelect == $past(regWdata[7:6]))
      else $error("lock window field not taken from bits 7:6");
endmodule

// File: test/pdl_clock_source.sv
`timescale 1ns/1ps
// ****************************************************
// reference source and oscillator model
// ****************************************************
module pdl_clock_source (
   // control from the bench
   input  wire logic       refRun,
   input  wire logic [7:0] fbSkewNs,
   // pins toward the block
   output logic            refIn,
   output logic            fbIn,
   output logic            oscClk,
   output int              refCount
);
   int skew;

   // oscillator free-runs at 80 ns, phase unrelated to core_clk
   initial begin
      oscClk = 1'b0;
      #3;
      forever #40 oscClk = ~oscClk;
   end

   // feedback shares the reference period: equal divider ratios
   // a stopped reference idles low; gaps stay short, never 100
   initial begin
      refIn = 1'b0;
      fbIn = 1'b0;
      refCount = 0;
      #7;
      forever begin
         skew = int'(fbSkewNs);
         if (refRun) begin
            refIn = 1'b1;
            refCount++;
         end
         #(skew) fbIn = 1'b1;
         #(100 - skew) refIn = 1'b0;
         #(skew) fbIn = 1'b0;
         #(100 - skew);
      end
   end
endmodule

// File: test/pdl_core_bench.sv
`timescale 1ns/1ps
module pdl_core_bench
   import pdl_pkg::*;
();
   // ****************************************************
   // stimulus, scoreboard and verdict
   // ****************************************************
   logic               core_clk;
   logic               resetn;
   logic [3:0]         regAddr;
   logic [31:0]        regWdata;
   logic               regWr;
   logic               regRd;
   logic [31:0]        regRdata;
   logic               refIn;
   logic               fbIn;
   logic               oscClk;
   logic [NUM_OUT-1:0] outputClock;
   logic               lockDetect;
   logic               holdActive;
   logic               refRun;
   logic [7:0]         fbSkewNs;
   logic               rdPend;
   logic [31:0]        expQ[$];
   logic [14:0]        v;
   logic [31:0]        r;
   int                 refCount;
   int                 errors;
   int                 nTests;
   int                 b;

   pdl_core i_pdl_core (.core_clk(core_clk), .resetn(resetn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .refIn(refIn), .fbIn(fbIn),
      .oscillatorClockInput(oscClk), .outputClock(outputClock),
      .lockDetect(lockDetect), .holdActive(holdActive));
   pdl_clock_source i_pdl_clock_source (.refRun(refRun),
      .fbSkewNs(fbSkewNs), .refIn(refIn), .fbIn(fbIn), .oscClk(oscClk),
      .refCount(refCount));

   // 100 MHz core clock
   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      if (errors == 0 && nTests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask

   // expected read data is queued at launch, popped by the monitor
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      expQ.push_back(e);
      @(posedge core_clk);
      regRd <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (rdPend)
         check(regRdata, expQ.pop_front());
      rdPend <= regRd;
   end

   function automatic int divOf(input int c);
      return (c < 5) ? (1 << c) : 8;
   endfunction

   // cycles to next rising edge; bounded so a dead output cannot hang
   task automatic riseWait(input int n, output int c);
      c = 0;
      while (outputClock[n] !== 1'b0 && c < 400) begin
         cyc(1);
         c++;
      end
      while (outputClock[n] !== 1'b1 && c < 400) begin
         cyc(1);
         c++;
      end
   endtask

   // oscillator period is 8 core cycles
   task automatic measure(input int n, input int code);
      int c;
      riseWait(n, c);
      riseWait(n, c);
      check(32'(c), 32'(8 * divOf(code)));
   endtask

   task automatic waitRef(input int k);
      wait (refCount == k);
      cyc(10);
   endtask

   // hang guard, well beyond the expected run length
   initial begin
      #500_000;
      errors++;
      end_of_test();
   end

   // main sequence
   initial begin
      void'($urandom(3023));
      {resetn, regWr, regRd, refRun} = 4'h0;
      {regAddr, regWdata, fbSkewNs} = '0;
      errors = 0;
      nTests = 0;
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      rd(REG_DIVSEL, 32'h0000_3688);
      rd(REG_CTRL, 32'h0000_0000);
      for (int n = 0; n < NUM_OUT; n++)
         measure(n, (n < 3) ? n : 3);
      for (int c = 0; c < 8; c++) begin
         for (int n = 0; n < NUM_OUT; n++)
            v[3*n +: 3] = 3'((c + n) % 8);
         wr(REG_DIVSEL, 32'(v));
         // let the new selects reach the outputs before aligning
         cyc(2);
         for (int n = 0; n < NUM_OUT; n++)
            measure(n, (c + n) % 8);
      end
      repeat (4) begin
         r = $urandom;
         wr(REG_DIVSEL, r);
         rd(REG_DIVSEL, r & 32'h0000_7fff);
      end
      wr(4'hc, 32'hffff_ffff);
      rd(4'hc, 32'h0000_0000);
      rd(REG_DIVSEL, r & 32'h0000_7fff);
      for (int w = 0; w < 4; w++) begin
         wr(REG_CTRL, 32'(w << CTRL_WIN_LSB));
         rd(REG_CTRL, 32'(w << CTRL_WIN_LSB));
      end
      // lock qualification, loss and requalification
      refRun <= 1'b1;
      waitRef(4);
      check(32'(lockDetect), 32'h0000_0000);
      waitRef(5);
      check(32'(lockDetect), 32'h0000_0001);
      rd(REG_STATUS, 32'h0000_0051);
      wait (refCount == 6);
      fbSkewNs = 8'h32;
      waitRef(7);
      check(32'(lockDetect), 32'h0000_0000);
      fbSkewNs = 8'h00;
      waitRef(11);
      check(32'(lockDetect), 32'h0000_0000);
      waitRef(12);
      check(32'(lockDetect), 32'h0000_0001);
      // missing reference with hold disabled, then enabled
      refRun = 1'b0;
      cyc(60);
      check(32'(holdActive), 32'h0000_0000);
      wr(REG_CTRL, 32'h0000_0004);
      b = refCount;
      refRun = 1'b1;
      wait (refCount == b + 3);
      refRun = 1'b0;
      cyc(20);
      check(32'(holdActive), 32'h0000_0000);
      cyc(25);
      check(32'(holdActive), 32'h0000_0001);
      refRun = 1'b1;
      waitRef(b + 4);
      check(32'(holdActive), 32'h0000_0000);
      refRun = 1'b0;
      cyc(45);
      check(32'(holdActive), 32'h0000_0001);
      wr(REG_CTRL, 32'h0000_0000);
      cyc(3);
      check(32'(holdActive), 32'h0000_0000);
      cyc(60);
      check(32'(holdActive), 32'h0000_0000);
      end_of_test();
   end
endmodule
